// [rtl/rcd_ca_regs.vh]
// constants for the command/address register front end
`ifndef RCD_CA_REGS_VH
`define RCD_CA_REGS_VH
// address bus width and command/address word layout
`define ADDR_W          18
`define BANK_W          2
`define CS_W            4
// rank-select mode encodings for rank_select_mode_field
`define MODE_TWO_DIRECT 2'h0
`define MODE_FOUR_DIRECT 2'h1
`define MODE_FOUR_ENCODED 2'h2
// configuration word numbers reached by a control word write
`define CW_PARITY       4'hE
`define CW_MODULE       4'hD
// field positions inside configuration words
`define CW_PARITY_EN_BIT 0
`define CW_MODE_LSB     0
// reset values
`define PARITY_EN_RST   1'h0
`define MODE_RST        2'h0
`endif

// [rtl/addr_mirror.v]
// address and bank swap for mirrored ranks
`timescale 1ns/1ps
module addr_mirror
(
  input  wire [17:0] addr_in,     // connector address
  input  wire [1:0]  ba_in,       // connector bank address
  input  wire [1:0]  bg_in,       // connector bank group
  input  wire        mirror,      // rank is mirrored
  output reg  [17:0] addr_out,    // address toward dram
  output reg  [1:0]  ba_out,      // bank address toward dram
  output reg  [1:0]  bg_out       // bank group toward dram
);
  ////////////////////////////////////////////////////////////////////////////
  // pure rewiring; the same swap for every access keeps reads consistent
  always @*
  begin
    addr_out = addr_in;
    ba_out   = ba_in;
    bg_out   = bg_in;
    if (mirror)
    begin
      addr_out[3]  = addr_in[4];
      addr_out[4]  = addr_in[3];
      addr_out[5]  = addr_in[6];
      addr_out[6]  = addr_in[5];
      addr_out[7]  = addr_in[8];
      addr_out[8]  = addr_in[7];
      addr_out[11] = addr_in[13];
      addr_out[13] = addr_in[11];
      ba_out       = {ba_in[0], ba_in[1]};
      bg_out       = {bg_in[0], bg_in[1]};
    end
  end
endmodule // addr_mirror

// [rtl/rcd_ca_front.v]
// command/address register with parity check and rank select
`timescale 1ns/1ps
`include "rcd_ca_regs.vh"
module rcd_ca_front
#(
  parameter ADDR_W = `ADDR_W      // address width
)
(
  input  wire              core_clk,      // core clock
  input  wire              resetn,        // async reset, active low
  input  wire              cmd_clk,       // host command clock pin
  input  wire [3:0]        cs_n_in,       // host chip selects, active low
  input  wire              act_n_in,      // activate
  input  wire              ras_n_in,      // command bit
  input  wire              cas_n_in,      // command bit
  input  wire              we_n_in,       // command bit
  input  wire [ADDR_W-1:0] addr_in,       // connector address
  input  wire [1:0]        ba_in,         // bank address
  input  wire [1:0]        bg_in,         // bank group
  input  wire              host_parity_in,// host parity bit
  input  wire              cw_write,      // command-bus control word write
  input  wire              i2c_cw_valid,  // two-wire control word write pulse
  input  wire [3:0]        i2c_cw_num,    // two-wire word number
  input  wire [3:0]        i2c_cw_data,   // two-wire word data
  output reg  [3:0]        dram_cs_n,     // rank selects toward dram
  output reg               dram_act_n,    // forwarded activate
  output reg               dram_ras_n,    // forwarded command
  output reg               dram_cas_n,    // forwarded command
  output reg               dram_we_n,     // forwarded command
  output reg  [ADDR_W-1:0] dram_addr,     // forwarded address
  output reg  [1:0]        dram_ba,       // forwarded bank
  output reg  [1:0]        dram_bg,       // forwarded group
  output reg               alert_out,     // alert pin value, always low
  output reg               alert_oe_n,    // low drives alert low
  output reg               parity_en,     // parity config bit
  output reg  [1:0]        rank_select_mode_field // rank mode field
);
  ////////////////////////////////////////////////////////////////////////////
  // command clock edge finder: three stages, rise seen when second is high and third low
  reg ck_s1;  // first stage, read by ck_s2 only
  reg ck_s2;  // second stage
  reg ck_s3;  // third stage
  wire ck_rise = ck_s2 & ~ck_s3;  // one-cycle enable on host clock rise

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ck_s1 <= 1'h0;
      ck_s2 <= 1'h0;
      ck_s3 <= 1'h0;
    end
    else
    begin
      ck_s1 <= cmd_clk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample the bus on the host edge; limitation: bus must be stable
  // for several core cycles around the host edge
  reg [3:0]        s_cs_n;  // sampled chip selects
  reg [3:0]        s_cmd;   // act, ras, cas, we
  reg [ADDR_W-1:0] s_addr;  // sampled address
  reg [1:0]        s_ba;    // sampled bank
  reg [1:0]        s_bg;    // sampled group
  reg              s_par;   // sampled parity
  reg              s_cw;    // sampled control word write
  reg              s_vld;   // sample taken this cycle

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_cs_n <= 4'hF;
      s_cmd  <= 4'hF;
      s_addr <= {ADDR_W{1'b0}};
      s_ba   <= 2'h0;
      s_bg   <= 2'h0;
      s_par  <= 1'h0;
      s_cw   <= 1'h0;
      s_vld  <= 1'h0;
    end
    else
    begin
      s_vld <= ck_rise;
      if (ck_rise)
      begin
        s_cs_n <= cs_n_in;
        s_cmd  <= {act_n_in, ras_n_in, cas_n_in, we_n_in};
        s_addr <= addr_in;
        s_ba   <= ba_in;
        s_bg   <= bg_in;
        s_par  <= host_parity_in;
        s_cw   <= cw_write;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // even parity over command, address and parity bit
  function parity_bad;
    input [3:0]        cmd;
    input [ADDR_W-1:0] a;
    input [1:0]        ba;
    input [1:0]        bg;
    input              p;
    begin
      parity_bad = ^{cmd, a, ba, bg, p};
    end
  endfunction

  // only selected (qualified) cycles are checked
  wire qualified = s_vld & ~(&s_cs_n);
  wire par_err   = qualified & parity_en & parity_bad(s_cmd, s_addr, s_ba, s_bg, s_par);

  ////////////////////////////////////////////////////////////////////////////
  // rank decode per mode; ranks 1 and 3 are mirrored
  reg [3:0] next_cs_n;  // decoded rank selects
  always @*
  begin
    next_cs_n = 4'hF;
    case (rank_select_mode_field)
      `MODE_TWO_DIRECT:   next_cs_n = {2'h3, s_cs_n[1:0]};
      `MODE_FOUR_DIRECT:  next_cs_n = s_cs_n;
      `MODE_FOUR_ENCODED:
      begin
        // cs0 low selects, cs1 picks the pair half, cs2 the pair
        if (!s_cs_n[0])
          next_cs_n = ~(4'h1 << {s_cs_n[2], s_cs_n[1]});
      end
      default:            next_cs_n = {2'h3, s_cs_n[1:0]};
    endcase
  end

  wire mirror = ~next_cs_n[1] | ~next_cs_n[3];
  wire [ADDR_W-1:0] m_addr;  // swapped address
  wire [1:0]        m_ba;    // swapped bank
  wire [1:0]        m_bg;    // swapped group

  addr_mirror u_mirror
  (
    .addr_in  (s_addr),
    .ba_in    (s_ba),
    .bg_in    (s_bg),
    .mirror   (mirror),
    .addr_out (m_addr),
    .ba_out   (m_ba),
    .bg_out   (m_bg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // forward stage; a failed command leaves all ranks deselected
  wire fwd = qualified & ~par_err & ~s_cw;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dram_cs_n  <= 4'hF;
      dram_act_n <= 1'h1;
      dram_ras_n <= 1'h1;
      dram_cas_n <= 1'h1;
      dram_we_n  <= 1'h1;
      dram_addr  <= {ADDR_W{1'b0}};
      dram_ba    <= 2'h0;
      dram_bg    <= 2'h0;
    end
    else if (s_vld)
    begin
      dram_cs_n  <= fwd ? next_cs_n : 4'hF;
      dram_act_n <= s_cmd[3];
      dram_ras_n <= s_cmd[2];
      dram_cas_n <= s_cmd[1];
      dram_we_n  <= s_cmd[0];
      dram_addr  <= m_addr;
      dram_ba    <= m_ba;
      dram_bg    <= m_bg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration words: command bus uses addr[7:4] number, addr[3:0] data
  wire bus_cw = qualified & s_cw & ~par_err;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      parity_en              <= `PARITY_EN_RST;
      rank_select_mode_field <= `MODE_RST;
    end
    else if (bus_cw)
    begin
      if (s_addr[7:4] == `CW_PARITY)
        parity_en <= s_addr[`CW_PARITY_EN_BIT];
      if (s_addr[7:4] == `CW_MODULE)
        rank_select_mode_field <= s_addr[`CW_MODE_LSB+1:`CW_MODE_LSB];
    end
    else if (i2c_cw_valid)
    begin
      if (i2c_cw_num == `CW_PARITY)
        parity_en <= i2c_cw_data[`CW_PARITY_EN_BIT];
      if (i2c_cw_num == `CW_MODULE)
        rank_select_mode_field <= i2c_cw_data[`CW_MODE_LSB+1:`CW_MODE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert: open drain, pulled low for one host cycle per error
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alert_out  <= 1'h0;
      alert_oe_n <= 1'h1;
    end
    else
    begin
      alert_out <= 1'h0;
      if (par_err)
        alert_oe_n <= 1'h0;
      else if (ck_rise)
        alert_oe_n <= 1'h1;
    end
  end
endmodule // rcd_ca_front

// [testbench/rcd_ca_chk.sv]
// checker for the command/address front end
`timescale 1ns/1ps
module rcd_ca_chk
(
  input wire        core_clk, resetn, cmd_clk, cw_write, alert_out, alert_oe_n, parity_en,
  input wire [3:0]  cs_n_in, dram_cs_n,
  input wire [17:0] addr_in, dram_addr,
  input wire [1:0]  ba_in, bg_in, dram_ba, dram_bg, rank_select_mode_field
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // open-drain pin: only ever pulled low, never driven high
  a_alert_pin_low: assert property (alert_out == 1'b0)
    else $error("alert value driven high");
  a_alert_needs_en: assert property ($fell(alert_oe_n) |-> parity_en)
    else $error("alert raised with checking off");
  a_err_blocks: assert property ($fell(alert_oe_n) |-> dram_cs_n == 4'hF)
    else $error("errored command forwarded");
  a_one_rank: assert property ($countones(~dram_cs_n) <= 1)
    else $error("more than one rank selected");
  // 2 core cycles to see the rise, 2 more to update
  a_fwd_latency: assert property ($rose(cmd_clk) && cs_n_in == 4'hE && !parity_en
    && !cw_write && rank_select_mode_field == 2'h0 |-> ##[2:8] dram_cs_n == 4'hE)
    else $error("command not forwarded in time");
  a_rank0_straight: assert property ($fell(dram_cs_n[0]) |-> dram_addr == addr_in
    && dram_ba == ba_in && dram_bg == bg_in) else $error("rank 0 bus altered");
  a_rank1_addr_swap: assert property ($fell(dram_cs_n[1]) |-> {dram_addr[13],
    dram_addr[11], dram_addr[8:3]} == {addr_in[11], addr_in[13], addr_in[7], addr_in[8],
    addr_in[5], addr_in[6], addr_in[3], addr_in[4]}) else $error("mirror swap wrong");
  a_rank1_bank_swap: assert property ($fell(dram_cs_n[1]) |->
    {dram_ba, dram_bg} == {ba_in[0], ba_in[1], bg_in[0], bg_in[1]}) else $error("bank swap");
  a_rank1_keep: assert property ($fell(dram_cs_n[1]) |-> {dram_addr[17:14], dram_addr[12],
    dram_addr[10:9], dram_addr[2:0]} == {addr_in[17:14], addr_in[12], addr_in[10:9],
    addr_in[2:0]}) else $error("unswapped lines moved");
endmodule // rcd_ca_chk
bind rcd_ca_front rcd_ca_chk rcd_ca_chk_inst (.*);

// [testbench/host_model.sv]
// host controller model driving the command/address bus
`timescale 1ns/1ps
module host_model
(
  output reg        cmd_clk, act_n_in, ras_n_in, cas_n_in, we_n_in, host_parity_in, cw_write,
  output reg [3:0]  cs_n_in,
  output reg [17:0] addr_in,
  output reg [1:0]  ba_in, bg_in
);
  // idle: clock still, ranks deselected, command bits high
  initial
  begin
    {cmd_clk, cw_write, host_parity_in} = 3'h0;
    {addr_in, ba_in, bg_in}             = 22'h0;
    {cs_n_in, act_n_in, ras_n_in, cas_n_in, we_n_in} = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////
  // one 59 ns frame, bus held well around the single rise
  task send(input [3:0] cs, c, input [17:0] a, input [1:0] ba, bg, input cw, bad);
    begin
      #1;
      {cs_n_in, act_n_in, ras_n_in, cas_n_in, we_n_in} = {cs, c};
      {addr_in, ba_in, bg_in, cw_write} = {a, ba, bg, cw};
      host_parity_in = ^{c, a, ba, bg} ^ bad;
      #11 cmd_clk = 1'b1;
      #24 cmd_clk = 1'b0;
      // release just before a core edge, never on it
      #23 addr_in = ~addr_in; // released address, bank and group never show the old value
      {ba_in, bg_in} = ~{ba_in, bg_in};
      cs_n_in = 4'hF;
    end
  endtask
endmodule // host_model

// [testbench/testbench.sv]
// self-checking bench for the command/address front end
`timescale 1ns/1ps
`include "rcd_ca_regs.vh"
module testbench;
  reg         core_clk = 1'b0, resetn = 1'b0, i2c_cw_valid = 1'b0;
  reg  [3:0]  i2c_cw_num = 4'h0, i2c_cw_data = 4'h0;
  wire        cmd_clk, act_n_in, ras_n_in, cas_n_in, we_n_in, host_parity_in, cw_write;
  wire        dram_act_n, dram_ras_n, dram_cas_n, dram_we_n, alert_out, alert_oe_n, parity_en;
  wire [3:0]  cs_n_in, dram_cs_n;
  wire [17:0] addr_in, dram_addr;
  wire [1:0]  ba_in, bg_in, dram_ba, dram_bg, rank_select_mode_field;
  integer     err_count = 0, compares = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  host_model host_model_inst (.*);
  rcd_ca_front rcd_ca_front_inst (.*);
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input [31:0] seen, exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        err_count++;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // hang guard, far beyond the 170 or so cycles needed
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 4000)
    begin
      err_count++;
      wrap_up;
    end
  end
  function [17:0] mir(input [17:0] a);
    begin
      mir = a;
      {mir[3], mir[4], mir[5], mir[6], mir[7], mir[8], mir[11], mir[13]} =
        {a[4], a[3], a[6], a[5], a[8], a[7], a[13], a[11]};
    end
  endfunction
  // one command, then judge the forwarded bus and the alert pin
  task fwd(input [3:0] cs, ecs, input [17:0] a, input m, bad, eal);
    begin
      @(posedge core_clk) host_model_inst.send(cs, 4'h5, a, 2'h1, 2'h2, 1'b0, bad);
      chk("dram_cs_n", dram_cs_n, ecs);
      chk("alert_oe_n", alert_oe_n, eal);
      chk("alert_out", alert_out, 1'b0);
      if (ecs != 4'hF)
      begin
        chk("dram_addr", dram_addr, m ? mir(a) : a);
        chk("dram_ba_bg", {dram_ba, dram_bg}, m ? 4'h9 : 4'h6);
        chk("dram_cmd", {dram_act_n, dram_ras_n, dram_cas_n, dram_we_n}, 4'h5);
      end
    end
  endtask
  task cw(input [3:0] w, d, input bad);
    @(posedge core_clk) host_model_inst.send(4'hE, 4'h5, {10'h0, w, d}, 2'h0, 2'h0, 1'b1, bad);
  endtask
  task i2c(input [3:0] w, d);
    begin
      @(posedge core_clk) #1 {i2c_cw_valid, i2c_cw_num, i2c_cw_data} = {1'b1, w, d};
      @(posedge core_clk) #1 i2c_cw_valid = 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // two-select mode: ranks 0 and 1 pass, upper selects are dropped;
  // odd ranks carry bad parity with checking off and rank 1 still goes through
  task t_mirror;
    integer i;
    begin
      for (i = 0; i < 4; i++)
        fwd(~(4'h1 << i), i[1] ? 4'hF : ~(4'h1 << i), 18'h29AAE ^ i[1:0],
          i[0], i[0], 1'b1);
      // host pre-swaps a mode load so the mirrored rank sees the intended value
      fwd(4'hD, 4'hD, mir(18'h0A5C3), 1'b1, 1'b0, 1'b1);
    end
  endtask
  task t_parity;
    begin
      cw(`CW_PARITY, 4'h1, 1'b0);
      chk("parity_en", parity_en, 1'b1);
      fwd(4'hE, 4'hF, 18'h00F0F, 1'b0, 1'b1, 1'b0);
      fwd(4'hE, 4'hE, 18'h00F0F, 1'b0, 1'b0, 1'b1);
      cw(`CW_MODULE, `MODE_FOUR_ENCODED, 1'b1);
      chk("mode", rank_select_mode_field, `MODE_TWO_DIRECT);
      chk("alert_oe_n", alert_oe_n, 1'b0);
    end
  endtask
  task t_modes;
    begin
      i2c(`CW_MODULE, `MODE_FOUR_ENCODED);
      chk("mode", rank_select_mode_field, `MODE_FOUR_ENCODED);
      fwd(4'hA, 4'hD, 18'h29AAE, 1'b1, 1'b0, 1'b1);
      fwd(4'hC, 4'hB, 18'h29AAE, 1'b0, 1'b0, 1'b1);
      cw(`CW_MODULE, `MODE_FOUR_DIRECT, 1'b0);
      chk("mode", rank_select_mode_field, `MODE_FOUR_DIRECT);
      fwd(4'h7, 4'h7, 18'h155AA, 1'b1, 1'b0, 1'b1);
      i2c(`CW_PARITY, 4'h0);
      i2c(`CW_MODULE, `MODE_TWO_DIRECT);
      chk("cfg", {parity_en, rank_select_mode_field}, 3'h0);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 resetn = 1'b1;
    chk("reset", {dram_cs_n, alert_oe_n, parity_en, rank_select_mode_field}, 8'hF8);
    t_mirror;
    t_parity;
    t_modes;
    wrap_up;
  end
endmodule // testbench
